// File: include/trace_capture_defs.svh
// Constants for the bus cycle trace capture block.
// Assumes inclusion by the package and by the capture module only.
`ifndef TRACE_CAPTURE_DEFS_SVH
`define TRACE_CAPTURE_DEFS_SVH
`define TRC_DEPTH_LOG2     22
`define TRC_ADDR_W         24
`define TRC_DATA_W         16
`define TRC_DELAY_W        16
`define TRC_DELAY_RST      16'h0000
`endif

// File: include/trace_capture_pkg.sv
// Types for the bus cycle trace capture block.
// Assumes the defs header is on the include path.
`include "trace_capture_defs.svh"
package trace_capture_pkg;
  typedef enum logic [1:0] {
    BW_8  = 2'h0,
    BW_16 = 2'h1
  } bus_width_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } access_size_t;
  typedef enum logic [1:0] {
    DIR_NONE  = 2'h0,
    DIR_READ  = 2'h1,
    DIR_WRITE = 2'h2
  } bus_dir_t;
  typedef enum logic [2:0] {
    ST_DATA_TRANSFER_CTRL_ACCESS = 3'h0,
    ST_SERIAL_COMM_UNIT_ACCESS   = 3'h1,
    ST_FETCH                     = 3'h2,
    ST_STANDBY                   = 3'h3,
    ST_SLEEP                     = 3'h4,
    ST_DATA_ACCESS               = 3'h5
  } cycle_status_t;
  typedef struct packed {
    logic [`TRC_ADDR_W-1:0] addr;
    logic [`TRC_DATA_W-1:0] data;
    bus_width_t             width;
    access_size_t           size;
    bus_dir_t               dir;
    logic                   cycle_invalid_flag;
    cycle_status_t          status;
  } trace_record_t;
  typedef enum logic [2:0] {
    CAP_IDLE  = 3'b001,
    CAP_RUN   = 3'b010,
    CAP_DELAY = 3'b100
  } cap_state_t;
endpackage : trace_capture_pkg

// File: logic/bus_cycle_trace_capture.sv
// Trace capture: records one entry per target bus cycle into trace memory.
// Assumes bus cycle inputs are synchronous to ref_clk_i (target bus clock),
// and the run flag comes from the debug controller on the same clock.
`timescale 1ns/10ps
module bus_cycle_trace_capture
  import trace_capture_pkg::*;
#(
  parameter int DEPTH_LOG2 = `TRC_DEPTH_LOG2
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      clk_en_i,
  input  wire logic                      prog_run_i,
  input  wire logic                      bus_cycle_i,
  input  wire trace_record_t             bus_rec_i,
  input  wire logic                      stop_cond_i,
  input  wire logic                      delay_en_i,
  input  wire logic [`TRC_DELAY_W-1:0]   delay_cnt_i,
  input  wire logic                      rd_req_i,
  input  wire logic signed [DEPTH_LOG2:0] rd_index_i,
  output logic                           capturing_o,
  output logic                           break_req_o,
  output logic                           rd_valid_o,
  output trace_record_t                  rd_rec_o,
  output logic [DEPTH_LOG2:0]            rec_count_o
);
  localparam int DEPTH = 1 << DEPTH_LOG2;
  typedef logic [DEPTH_LOG2-1:0] ptr_t;
  // A one-bit signed literal would read as minus one, so the step is sized.
  localparam logic signed [DEPTH_LOG2+1:0] ONE_S = 1;

  // ==========================================================================
  // Trace memory
  // ==========================================================================
  trace_record_t mem [DEPTH];

  cap_state_t                 state_r, state_nxt;
  ptr_t                       wr_ptr_r, wr_ptr_nxt;
  ptr_t                       zero_ptr_r, zero_ptr_nxt;
  logic                       zero_set_r, zero_set_nxt;
  logic [DEPTH_LOG2:0]        count_r, count_nxt;
  logic [`TRC_DELAY_W-1:0]    dly_r, dly_nxt;
  logic                       brk_r, brk_nxt;
  logic                       we;
  logic                       cap_r, cap_nxt;

  function automatic logic [DEPTH_LOG2:0] sat_inc(
    input logic [DEPTH_LOG2:0] c
  );
    sat_inc = (c == DEPTH[DEPTH_LOG2:0]) ? c : c + 1'b1;
  endfunction : sat_inc

  // ==========================================================================
  // Capture control
  // ==========================================================================
  always_comb begin
    state_nxt    = state_r;
    wr_ptr_nxt   = wr_ptr_r;
    zero_ptr_nxt = zero_ptr_r;
    zero_set_nxt = zero_set_r;
    count_nxt    = count_r;
    dly_nxt      = dly_r;
    brk_nxt      = 1'b0;
    we           = 1'b0;
    case (state_r)
      CAP_IDLE: begin
        if (prog_run_i) begin
          state_nxt    = CAP_RUN;
          wr_ptr_nxt   = '0;
          count_nxt    = '0;
          zero_set_nxt = 1'b0;
        end
      end
      CAP_RUN, CAP_DELAY: begin
        if (!prog_run_i) begin
          // Contents stay untouched for readout after the stop.
          state_nxt = CAP_IDLE;
        end else if (bus_cycle_i) begin
          we         = 1'b1;
          wr_ptr_nxt = wr_ptr_r + 1'b1; // Wraps over the oldest.
          count_nxt  = sat_inc(count_r);
          if (state_r == CAP_RUN && stop_cond_i && delay_en_i) begin
            zero_ptr_nxt = wr_ptr_r;
            zero_set_nxt = 1'b1;
            dly_nxt      = delay_cnt_i;
            state_nxt    = CAP_DELAY;
            brk_nxt      = (delay_cnt_i == `TRC_DELAY_RST);
          end else if (state_r == CAP_DELAY) begin
            if (dly_r != `TRC_DELAY_RST) begin
              dly_nxt = dly_r - 1'b1;
            end
            // Only the last delay cycle fires, so the request is one pulse.
            brk_nxt = (dly_r == 16'h0001);
          end
        end
      end
      default: state_nxt = CAP_IDLE;
    endcase
    // The capture flag is registered so the output comes from a flop.
    cap_nxt = (state_nxt != CAP_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r    <= CAP_IDLE;
      wr_ptr_r   <= '0;
      zero_ptr_r <= '0;
      zero_set_r <= 1'b0;
      count_r    <= '0;
      dly_r      <= `TRC_DELAY_RST;
      brk_r      <= 1'b0;
      cap_r      <= 1'b0;
    end else if (clk_en_i) begin
      state_r    <= state_nxt;
      wr_ptr_r   <= wr_ptr_nxt;
      zero_ptr_r <= zero_ptr_nxt;
      zero_set_r <= zero_set_nxt;
      count_r    <= count_nxt;
      dly_r      <= dly_nxt;
      brk_r      <= brk_nxt;
      cap_r      <= cap_nxt;
    end
  end

  // Every field of the bus record is stored whole.
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && we) begin
      mem[wr_ptr_r] <= bus_rec_i;
    end
  end

  // ==========================================================================
  // Readout by signed index
  // ==========================================================================
  // Index 0 is the newest record, or the stop-condition record when a delay
  // was armed; reads are refused while capture runs to avoid port clashes.
  ptr_t   base;
  ptr_t   rd_addr;
  logic   rd_ok;
  logic signed [DEPTH_LOG2+1:0] lo_lim, hi_lim, idx;

  always_comb begin
    base    = zero_set_r ? zero_ptr_r : ptr_t'(wr_ptr_r - 1'b1);
    idx     = {rd_index_i[DEPTH_LOG2], rd_index_i};
    rd_addr = ptr_t'(base + ptr_t'(rd_index_i[DEPTH_LOG2-1:0]));
    hi_lim  = zero_set_r
            ? $signed({2'b00, ptr_t'(wr_ptr_r - zero_ptr_r - 1'b1)})
            : '0;
    lo_lim  = hi_lim - $signed({1'b0, count_r}) + ONE_S;
    rd_ok   = (state_r == CAP_IDLE) && (count_r != '0) &&
              (idx <= hi_lim) && (idx >= lo_lim);
  end

  logic          rd_valid_r, rd_valid_nxt;
  trace_record_t rd_rec_r, rd_rec_nxt;

  // The record is zeroed in the flop itself when no read is accepted, so
  // the output needs no gate behind the register.
  always_comb begin
    rd_valid_nxt = rd_req_i && rd_ok;
    rd_rec_nxt   = rd_valid_nxt ? mem[rd_addr] : '0;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_r <= 1'b0;
      rd_rec_r   <= '0;
    end else if (clk_en_i) begin
      rd_valid_r <= rd_valid_nxt;
      rd_rec_r   <= rd_rec_nxt;
    end
  end

  assign rd_valid_o  = rd_valid_r;
  assign rd_rec_o    = rd_rec_r;
  assign capturing_o = cap_r;
  assign break_req_o = brk_r;
  assign rec_count_o = count_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_start_capture: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && state_r == CAP_IDLE && prog_run_i |=> capturing_o)
    else $error("capture did not start with program run");
  a_stop_capture: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && capturing_o && !prog_run_i |=> !capturing_o)
    else $error("capture did not stop with program stop");
  a_every_cycle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && capturing_o && prog_run_i && bus_cycle_i
    |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1)
    else $error("bus cycle not recorded");
  a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !capturing_o && !prog_run_i |=> $stable(wr_ptr_r) && $stable(count_r))
    else $error("trace memory state changed after stop");
  a_count_sat: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_r <= DEPTH[DEPTH_LOG2:0])
    else $error("record count beyond memory depth");
  a_zero_mark: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && state_r == CAP_RUN && prog_run_i && bus_cycle_i &&
    stop_cond_i && delay_en_i |=> zero_set_r && zero_ptr_r == $past(wr_ptr_r))
    else $error("stop condition cycle not marked as index zero");
  a_newest_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !zero_set_r |-> hi_lim == 0)
    else $error("newest record not index zero without delay");

  // Besides the break, delay, count and state checks, those below follow each
  // stored field from the bus into memory and back out, since a dropped field
  // would not disturb the pointers at all.

  a_break_once: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    brk_r |=> !brk_r)
    else $error("break request longer than one cycle");

  a_delay_step: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && state_r == CAP_DELAY && prog_run_i && bus_cycle_i &&
    dly_r != `TRC_DELAY_RST |=> dly_r == $past(dly_r) - 1'b1)
    else $error("delay count did not step with a bus cycle");

  a_count_step: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we && count_r != DEPTH[DEPTH_LOG2:0]
    |=> count_r == $past(count_r) + 1'b1)
    else $error("record count did not follow the capture");

  a_wrap_full: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we && count_r == DEPTH[DEPTH_LOG2:0]
    |=> count_r == DEPTH[DEPTH_LOG2:0])
    else $error("full memory lost its record count");

  a_no_idle_write: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_r == CAP_IDLE |-> !we)
    else $error("trace memory written while stopped");

  a_capture_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    capturing_o == (state_r != CAP_IDLE))
    else $error("capture flag disagrees with capture state");

  a_state_onehot: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    $onehot(state_r))
    else $error("capture state not one-hot");

  a_store_addr: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we |=> mem[$past(wr_ptr_r)] == $past(bus_rec_i))
    else $error("bus record not stored whole");

  a_store_dir: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we |=> mem[$past(wr_ptr_r)].dir == $past(bus_rec_i.dir))
    else $error("bus direction not stored");

  a_store_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we |=> mem[$past(wr_ptr_r)].cycle_invalid_flag ==
    $past(bus_rec_i.cycle_invalid_flag))
    else $error("cycle invalid flag not stored");

  a_store_status: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we |=> mem[$past(wr_ptr_r)].status ==
    $past(bus_rec_i.status))
    else $error("cycle status not stored");

  a_cpu_status: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we && bus_rec_i.status inside {ST_STANDBY, ST_SLEEP,
    ST_DATA_ACCESS} |=> mem[$past(wr_ptr_r)].status == $past(bus_rec_i.status))
    else $error("processor status not stored");

  // A read taken while capture runs would share the memory port with the
  // write, so it is refused rather than arbitrated.
  a_read_refused: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && rd_req_i && state_r != CAP_IDLE |=> !rd_valid_o)
    else $error("read accepted during capture");

  a_read_data: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && rd_req_i && rd_ok
    |=> rd_valid_o && rd_rec_o == $past(mem[rd_addr]))
    else $error("read returned the wrong record");

  a_read_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !rd_valid_o |-> rd_rec_o == '0)
    else $error("read record not zero without valid");

  a_size_kept: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && we |=> mem[$past(wr_ptr_r)].size == $past(bus_rec_i.size) &&
    mem[$past(wr_ptr_r)].width == $past(bus_rec_i.width))
    else $error("bus width or access size not stored");
endmodule : bus_cycle_trace_capture

// File: verification/target_bus_model.sv
// Target bus stand-in: one bus cycle per clock, or one every other clock.
// Assumes it shares ref_clk_i and rstn_i with the capture block.
`timescale 1ns/10ps
// ==========================================================
// Target bus model
module target_bus_model
  import trace_capture_pkg::*;
(
  input  wire logic     ref_clk_i,
  input  wire logic     rstn_i,
  input  wire logic     run_i,
  input  wire logic     slow_i,
  output logic          bus_cycle_o,
  output trace_record_t bus_rec_o
);
  logic [23:0] n_r;
  logic        go;
  assign go = run_i && !(slow_i && bus_cycle_o);
  // Every field walks through all its codes so each one gets stored.
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_r         <= 24'h00_0000;
      bus_cycle_o <= 1'b0;
      bus_rec_o   <= '0;
    end else begin
      bus_cycle_o <= go;
      if (go) begin
        n_r       <= n_r + 24'h00_0001;
        bus_rec_o <= '{n_r, ~n_r[15:0], n_r[0] ? BW_16 : BW_8,
                       access_size_t'(2'(n_r % 3)),
                       bus_dir_t'(2'((n_r + 1) % 3)), n_r[3],
                       cycle_status_t'(3'(n_r % 6))};
      end else begin
        // Between cycles the lines keep moving, never a stale copy.
        bus_rec_o <= trace_record_t'(~bus_rec_o);
      end
    end
  end
endmodule : target_bus_model

// File: verification/tb.sv
// Self-checking bench for the trace capture block, depth cut to 16.
// Assumes the package and the target bus model are compiled first.
`timescale 1ns/10ps
// ==========================================================
// Bench
module tb
  import trace_capture_pkg::*;
;
  localparam int DL = 4;
  localparam int DEPTH = 1 << DL;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, prog_run_i = 1'b0, slow = 1'b0;
  logic stop_cond_i = 1'b0, delay_en_i = 1'b0, rd_req_i = 1'b0, cap_r = 1'b0;
  logic [15:0] delay_cnt_i = 16'h0003;
  logic signed [DL:0] rd_index_i = '0;
  logic bus_cycle, capturing_o, break_req_o, rd_valid_o;
  logic [DL:0] rec_count_o;
  trace_record_t bus_rec, rd_rec_o, q[$];
  int sp = -1, n_fail = 0, checks_done = 0, k;
  int rows[6] = '{0, -1, -8, -9, 1, -16};
  always #20 ref_clk_i = ~ref_clk_i;
  bus_cycle_trace_capture #(.DEPTH_LOG2(DL)) bus_cycle_trace_capture_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1),
    .prog_run_i(prog_run_i), .bus_cycle_i(bus_cycle), .bus_rec_i(bus_rec),
    .stop_cond_i(stop_cond_i), .delay_en_i(delay_en_i),
    .delay_cnt_i(delay_cnt_i), .rd_req_i(rd_req_i), .rd_index_i(rd_index_i),
    .capturing_o(capturing_o), .break_req_o(break_req_o),
    .rd_valid_o(rd_valid_o), .rd_rec_o(rd_rec_o), .rec_count_o(rec_count_o));
  target_bus_model target_bus_model_inst (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .run_i(prog_run_i), .slow_i(slow),
    .bus_cycle_o(bus_cycle), .bus_rec_o(bus_rec));
  // Reference capture: a run starts one edge after the run flag rises.
  always @(posedge ref_clk_i) begin
    cap_r <= prog_run_i;
    if (prog_run_i && !cap_r) begin
      q.delete();
      sp = -1;
    end else if (cap_r && prog_run_i && bus_cycle) begin
      if (stop_cond_i && delay_en_i && sp < 0) sp = q.size();
      q.push_back(bus_rec);
    end
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(int idx, logic idle);
    int b, lo, n;
    logic ok;
    n = q.size();
    b = delay_en_i ? sp : n - 1;
    lo = n > DEPTH ? n - DEPTH : 0;
    ok = idle && n > 0 && idx <= n - 1 - b && b + idx >= lo;
    @(posedge ref_clk_i);
    rd_req_i <= 1'b1;
    rd_index_i <= idx[DL:0];
    @(posedge ref_clk_i);
    rd_req_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("rd_valid_o", ok, rd_valid_o);
    chk("rd_rec_o", ok ? q[b + idx] : '0, rd_rec_o);
  endtask : rd
  task automatic go(logic v);
    @(posedge ref_clk_i);
    prog_run_i <= v;
    repeat (2) @(negedge ref_clk_i);
    chk("capturing_o", v, capturing_o);
  endtask : go
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    chk("reset outputs", '0, {capturing_o, rd_valid_o, rec_count_o});
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(0, 1'b1);
    go(1'b1);
    repeat (8) @(posedge ref_clk_i);
    go(1'b0);
    chk("rec_count_o", q.size(), rec_count_o);
    foreach (rows[i]) rd(rows[i], 1'b1);
    @(posedge ref_clk_i);
    slow <= 1'b1;
    go(1'b1);
    rd(0, 1'b0);
    repeat (36) @(posedge ref_clk_i);
    go(1'b0);
    chk("rec_count_o", DEPTH, rec_count_o);
    for (int i = 0; i < 17; i++) rd(-i, 1'b1);
    @(posedge ref_clk_i);
    slow <= 1'b0;
    delay_en_i <= 1'b1;
    go(1'b1);
    @(posedge ref_clk_i);
    stop_cond_i <= 1'b1;
    @(posedge ref_clk_i) stop_cond_i <= 1'b0;
    k = 0;
    while (break_req_o !== 1'b1 && k < 12) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk("break_req_o", 1'b1, break_req_o);
    @(negedge ref_clk_i);
    chk("break_req_o", 1'b0, break_req_o);
    go(1'b0);
    for (int i = -3; i < 12; i++) rd(i, 1'b1);
    summarize();
  end
endmodule : tb
